// File: verification/cvi_cpu_model.sv
// Behavioural CPU core issuing acknowledge pairs and taking the vector
`timescale 1ns/1ps
module cvi_cpu_model (
	// Clock
	input wire core_clk,
	// Vector from the controller pair
	input wire [7:0] peripheral_data_bus,
	input wire peripheral_data_oe,
	// Acknowledge strobe
	output reg ack_cycle
);
	initial ack_cycle = 1'b0;
	// Gap 0 gives back-to-back pulses; a missing vector returns unknown so it never matches
	task ack(input integer gap, output logic [7:0] vec);
		begin
			@(posedge core_clk);
			ack_cycle <= 1'b1;
			@(posedge core_clk);
			if (gap > 0) begin
				ack_cycle <= 1'b0;
				repeat (gap) @(posedge core_clk);
				ack_cycle <= 1'b1;
			end
			@(posedge core_clk);
			ack_cycle <= 1'b0;
			// The vector stands only in the cycle after the second pulse
			#1 vec = peripheral_data_oe ? peripheral_data_bus : 8'hXX;
		end
	endtask
endmodule // cvi_cpu_model

// File: verification/cvi_irq_pair_assertions.sv
// Port checker for the cascaded interrupt controller pair
`timescale 1ns/1ps
module cvi_irq_pair_chk (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Register port
	input wire [7:0] io_addr,
	input wire [7:0] io_wdata,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_rdata,
	// Request sources
	input wire timer0_out,
	input wire rtc_irq,
	input wire [15:0] irq_pin,
	// CPU side
	input wire cpu_irq_out,
	input wire ack_cycle,
	input wire [7:0] peripheral_data_bus,
	input wire peripheral_data_oe
);
	// High while the next pulse is the second of a pair
	reg ph_q;
	wire first_ack;
	assign first_ack = ack_cycle && !ph_q;
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			ph_q <= 1'b0;
		else if (ack_cycle)
			ph_q <= ~ph_q;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_vec_one_cycle:
		assert property (peripheral_data_oe |=> !peripheral_data_oe) else $error("vector held");
	a_vec_after_second:
		assert property (ack_cycle && ph_q |=> peripheral_data_oe) else $error("no vector");
	a_vec_has_cause:
		assert property (peripheral_data_oe |-> $past(ack_cycle) && $past(ph_q))
			else $error("stray vector");
	a_no_vec_first:
		assert property (first_ack |=> !peripheral_data_oe) else $error("vector on first ack");
	a_irq_drop_ack:
		assert property (first_ack |=> !cpu_irq_out) else $error("irq held after ack");
	a_mask_all_quiet:
		assert property (io_wr && io_addr == 8'h21 && io_wdata == 8'hFF |-> ##3 !cpu_irq_out)
			else $error("irq with all masked");
	a_rdata_idle_zero:
		assert property (!$past(io_rd) |-> io_rdata == 8'h00) else $error("read data not idle");
	a_unmapped_read_zero:
		assert property (io_rd && !(io_addr[7:1] inside {7'h10, 7'h50}) |=> io_rdata == 8'h00)
			else $error("unmapped read answered");
	cover property (first_ack && cpu_irq_out);
	cover property (peripheral_data_oe && peripheral_data_bus[2:0] == 3'h7);
	cover property (io_wr && io_addr == 8'hA0);
endmodule // cvi_irq_pair_chk

bind cvi_irq_pair cvi_irq_pair_chk chk_u (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr),
	.io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
	.timer0_out(timer0_out), .rtc_irq(rtc_irq), .irq_pin(irq_pin), .cpu_irq_out(cpu_irq_out),
	.ack_cycle(ack_cycle), .peripheral_data_bus(peripheral_data_bus),
	.peripheral_data_oe(peripheral_data_oe));

// File: verification/tb_cvi_irq_pair.sv
// Testbench for the cascaded interrupt controller pair
`timescale 1ns/1ps
module tb_cvi_irq_pair;
	reg core_clk = 1'b0;
	reg rstn = 1'b0;
	reg [7:0] io_addr = 8'h00;
	reg [7:0] io_wdata = 8'h00;
	reg io_wr = 1'b0;
	reg io_rd = 1'b0;
	reg [17:0] src = 18'h00000;
	wire [7:0] io_rdata;
	wire [7:0] vbus;
	wire cpu_irq_out;
	wire ack_cycle;
	wire voe;
	integer miscompares = 0;
	integer compares = 0;
	integer c;
	integer s;
	always #2 core_clk = ~core_clk;
	cvi_irq_pair dut_u (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .timer0_out(src[16]),
		.rtc_irq(src[17]), .irq_pin(src[15:0]), .cpu_irq_out(cpu_irq_out), .ack_cycle(ack_cycle),
		.peripheral_data_bus(vbus), .peripheral_data_oe(voe));
	cvi_cpu_model cpu_u (.core_clk(core_clk), .peripheral_data_bus(vbus),
		.peripheral_data_oe(voe), .ack_cycle(ack_cycle));
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("wrong value %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		begin
			@(posedge core_clk);
			io_addr <= a;
			io_wdata <= d;
			io_wr <= 1'b1;
			@(posedge core_clk);
			io_wr <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		begin
			@(posedge core_clk);
			io_addr <= a;
			io_rd <= 1'b1;
			@(posedge core_clk);
			io_rd <= 1'b0;
			#1 chk(what, exp, io_rdata);
			@(posedge core_clk);
		end
	endtask
	task init(input logic [7:0] b, input logic [7:0] vb, input logic [7:0] w3, input logic [7:0] w4);
		begin
			wr(b, 8'h11);
			wr(b + 8'h01, vb);
			wr(b + 8'h01, w3);
			wr(b + 8'h01, w4);
		end
	endtask
	// Pins pass a synchroniser, so give the request time to reach the output
	task settle(input logic exp);
		begin
			repeat (12) @(posedge core_clk);
			#1 chk("cpu_irq_out", {7'h00, exp}, {7'h00, cpu_irq_out});
			@(posedge core_clk);
		end
	endtask
	task take(input logic [7:0] exp, input integer gap);
		logic [7:0] got;
		begin
			cpu_u.ack(gap, got);
			chk("vector", exp, got);
			@(posedge core_clk);
		end
	endtask
	task conclude;
		begin
			$display("compares %0d miscompares %0d", compares, miscompares);
			if (miscompares == 0 && compares > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	initial begin
		#100000;
		miscompares = miscompares + 1;
		conclude;
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		rd(8'h21, 8'h00, "mask");
		rd(8'h22, 8'h00, "unmapped");
		init(8'h20, 8'h08, 8'h04, 8'h01);
		init(8'hA0, 8'h70, 8'h02, 8'h01);
		take(8'h0F, 0);
		wr(8'h20, 8'h0B);
		for (c = 0; c < 16; c = c + 1) if (c != 2) begin
			s = (c == 0) ? 16 : (c == 8) ? 17 : c;
			src[s] <= 1'b1;
			settle(1'b1);
			take((c < 8) ? 8'h08 + c[7:0] : 8'h68 + c[7:0], c % 3);
			rd(8'h20, (c < 8) ? 8'h01 << c : 8'h04, "in service");
			if (c >= 8)
				wr(8'hA0, 8'h20);
			wr(8'h20, 8'h20);
			rd(8'h20, 8'h00, "in service");
			src[s] <= 1'b0;
		end
		src[5] <= 1'b1;
		src[3] <= 1'b1;
		settle(1'b1);
		take(8'h0B, 1);
		settle(1'b0);
		src[1] <= 1'b1;
		settle(1'b1);
		take(8'h09, 2);
		rd(8'h20, 8'h0A, "in service");
		wr(8'h20, 8'h20);
		rd(8'h20, 8'h08, "in service");
		wr(8'h20, 8'h63);
		settle(1'b1);
		take(8'h0D, 0);
		wr(8'h20, 8'h65);
		rd(8'h20, 8'h00, "in service");
		src[5:1] <= 5'h08;
		settle(1'b1);
		wr(8'h21, 8'hFF);
		settle(1'b0);
		rd(8'h21, 8'hFF, "mask");
		wr(8'h20, 8'h0A);
		rd(8'h20, 8'h10, "pending");
		wr(8'h21, 8'hEF);
		settle(1'b1);
		take(8'h0C, 1);
		wr(8'h20, 8'h6B);
		wr(8'h21, 8'h10);
		wr(8'h20, 8'h20);
		rd(8'h20, 8'h10, "in service");
		wr(8'h20, 8'h48);
		wr(8'h21, 8'h00);
		wr(8'h20, 8'h20);
		rd(8'h20, 8'h00, "in service");
		src[4] <= 1'b0;
		init(8'h20, 8'h08, 8'h04, 8'h03);
		wr(8'h20, 8'h0B);
		wr(8'h20, 8'h80);
		src[6] <= 1'b1;
		settle(1'b1);
		take(8'h0E, 1);
		rd(8'h20, 8'h00, "in service");
		// Channel 6 was served last, so channel 7 now outranks channel 5
		src[7] <= 1'b1;
		src[5] <= 1'b1;
		settle(1'b1);
		take(8'h0F, 0);
		settle(1'b1);
		take(8'h0D, 1);
		conclude;
	end
endmodule // tb_cvi_irq_pair

// File: verilog/cvi_irq_pair.v
// Master and slave vectored interrupt controllers joined in cascade
// Contract
// - Master answers at ports 020h-021h, slave at 0A0h-0A1h.
// - Slave interrupt output feeds master channel 2.
// - Timer channel 0 drives master channel 0, real-time clock drives slave channel 0.
// - Other channels come from external request pins 1,3-7 and 9-15.
// - A rising request input sets its pending bit; in level mode an active one does.
// - Eight in-service bits, one per channel, several may be set.
// - Mask register can disable any subset of channels, all included.
// - Resolver raises the CPU request when an unmasked request outranks service level.
// - First acknowledge sets in-service, clears pending, picks cascade address.
// - Slave compares master's cascade code with its 3-bit identity.
// - Second acknowledge drives the 8-bit vector on the data bus.
// - Vector bits 7-3 from init word two, bits 2-0 channel number.
// - Automatic mode clears in-service at end of second acknowledge.
// - Otherwise a done command from the CPU clears the in-service bit.
// - With no request at first acknowledge, master returns channel 7 vector.
// - Specific done clears the named bit, nonspecific the highest set.
// - In special mask mode nonspecific done skips masked in-service bits.
// - After init priority is fixed, channel 0 highest, 7 lowest.
// - A set in-service bit, unless masked in special mask mode, inhibits equal and lower priority requests.
// - Even write with bit 4 clear loads op word two or three by bit 3.
// - Automatic rotation makes the serviced channel lowest on every automatic done without a same-cycle explicit rotate or set-priority command.
`timescale 1ns/1ps
`include "cvi_regs.vh"

module cvi_irq_pair (
	// Clock and reset
	input wire core_clk,
	input wire rstn,
	// Register port
	input wire [7:0] io_addr,
	input wire [7:0] io_wdata,
	input wire io_wr,
	input wire io_rd,
	output reg [7:0] io_rdata,
	// Request sources
	input wire timer0_out,
	input wire rtc_irq,
	input wire [15:0] irq_pin,
	// CPU side
	output reg cpu_irq_out,
	input wire ack_cycle,
	output reg [7:0] peripheral_data_bus,
	output reg peripheral_data_oe
);

	// Lowest-to-highest scan, so the last hit is the highest priority
	function [3:0] pick;
		input [7:0] bits;
		input [2:0] low;
		integer k;
		reg [2:0] i;
		begin
			pick = 4'h0;
			for (k = 7; k >= 0; k = k - 1) begin
				i = low + 3'h1 + k[2:0];
				if (bits[i])
					pick = {1'b1, i};
			end
		end
	endfunction

	function [2:0] rank;
		input [2:0] idx;
		input [2:0] low;
		begin
			rank = idx - low - 3'h1;
		end
	endfunction

	function [7:0] onehot;
		input [2:0] idx;
		begin
			onehot = 8'h01 << idx;
		end
	endfunction

	// Pins cross in through three stages; a rise counts once stages two and three agree, a fall as soon as stage two drops
	reg [15:0] pin_s1_q;
	reg [15:0] pin_s2_q;
	reg [15:0] pin_s3_q;
	reg [15:0] pin_q;

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1_q <= 16'h0000;
			pin_s2_q <= 16'h0000;
			pin_s3_q <= 16'h0000;
			pin_q <= 16'h0000;
		end else begin
			pin_s1_q <= irq_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q <= (pin_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_s2_q & ~(pin_s2_q ^ pin_s3_q));
		end
	end

	wire [1:0] hit;
	wire [1:0] ctl_int;
	wire [7:0] ctl_req [0:1];
	wire [2:0] chan_w [0:1];
	wire [7:0] ident_w [0:1];
	wire [1:0] single_w;
	wire [7:0] vec_w [0:1];
	wire [7:0] rd_w [0:1];

	assign hit[0] = (io_addr[7:1] == `CVI_MST_BASE >> 1);
	assign hit[1] = (io_addr[7:1] == `CVI_SLV_BASE >> 1);

	// Timer and clock sources share this clock, so they need no synchroniser
	assign ctl_req[0] = {pin_q[7:3], ctl_int[1], pin_q[1], timer0_out};
	assign ctl_req[1] = {pin_q[15:9], rtc_irq};

	reg ack_phase_q;
	reg resp_slave_q;
	wire ack_first = ack_cycle & ~ack_phase_q;
	wire ack_second = ack_cycle & ack_phase_q;

	// Master offers a cascade code only for a resolved request on a cascade channel
	wire mst_casc = ctl_int[0] & ~single_w[0] & ident_w[0][chan_w[0]];
	wire slv_hit = mst_casc & (ident_w[1][2:0] == chan_w[0]);

	wire [1:0] take_ack;
	assign take_ack[0] = ack_first;
	assign take_ack[1] = ack_first & slv_hit;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : ctl
			reg [7:0] pend_q;
			reg [7:0] svc_q;
			reg [7:0] mask_q;
			reg [7:0] prev_q;
			reg [7:0] ident_q;
			reg [4:0] vbase_q;
			reg [2:0] low_q;
			reg [2:0] chan_q;
			reg [1:0] step_q;
			reg level_q;
			reg single_q;
			reg need4_q;
			reg auto_q;
			reg rot_auto_q;
			reg smm_q;
			reg ris_q;
			reg poll_q;
			reg took_q;

			wire [7:0] req = ctl_req[g];
			wire wr_even = io_wr & hit[g] & ~io_addr[0];
			wire wr_odd = io_wr & hit[g] & io_addr[0];
			wire poll_rd = io_rd & hit[g] & ~io_addr[0] & poll_q;
			wire take = take_ack[g] | poll_rd;
			wire [7:0] cand = pend_q & ~mask_q;
			wire [7:0] svc_eff = smm_q ? (svc_q & ~mask_q) : svc_q;
			wire [3:0] hr = pick(cand, low_q);
			wire [3:0] hs = pick(svc_eff, low_q);
			wire raise = hr[3] & (~hs[3] | (rank(hr[2:0], low_q) < rank(hs[2:0], low_q)));
			wire [2:0] chan = raise ? hr[2:0] : `CVI_SPUR_CHAN;
			wire [7:0] pend_seen = level_q ? req : ((pend_q & req) | (req & ~prev_q));
			wire is_init = wr_even & io_wdata[`CVI_W_INIT_BIT];
			wire is_op2 = wr_even & ~io_wdata[`CVI_W_INIT_BIT] & ~io_wdata[`CVI_W_OP3_BIT];
			wire is_op3 = wr_even & ~io_wdata[`CVI_W_INIT_BIT] & io_wdata[`CVI_W_OP3_BIT];
			wire done_cmd = is_op2 & io_wdata[`CVI_O2_DONE_BIT];
			wire done_spec = io_wdata[`CVI_O2_SPEC_BIT];
			wire [2:0] done_idx = done_spec ? io_wdata[2:0] : hs[2:0];
			wire done_ok = done_cmd & (done_spec | hs[3]);
			wire auto_done = ack_second & took_q & auto_q;
			wire [7:0] clr = (done_ok ? onehot(done_idx) : 8'h00) |
				(auto_done ? onehot(chan_q) : 8'h00);
			wire [7:0] setb = (take & raise) ? onehot(chan) : 8'h00;

			assign ctl_int[g] = raise;
			assign chan_w[g] = chan;
			assign ident_w[g] = ident_q;
			assign single_w[g] = single_q;
			assign vec_w[g] = {vbase_q, chan_q};
			assign rd_w[g] = io_addr[0] ? mask_q : poll_q ? {raise, 4'h0, chan} :
				ris_q ? svc_q : pend_q;

			always @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					pend_q <= 8'h00;
					svc_q <= 8'h00;
					mask_q <= `CVI_RST_MASK;
					prev_q <= 8'h00;
					ident_q <= `CVI_RST_IDENT;
					vbase_q <= `CVI_RST_VBASE;
					low_q <= `CVI_RST_LOWEST;
					chan_q <= `CVI_SPUR_CHAN;
					step_q <= `CVI_STEP_IDLE;
					level_q <= 1'b0;
					single_q <= 1'b0;
					need4_q <= 1'b0;
					auto_q <= 1'b0;
					rot_auto_q <= 1'b0;
					smm_q <= 1'b0;
					ris_q <= 1'b0;
					poll_q <= 1'b0;
					took_q <= 1'b0;
				end else begin
					prev_q <= req;
					pend_q <= pend_seen & ~setb;
					svc_q <= (svc_q & ~clr) | setb;
					if (take) begin
						chan_q <= chan;
						// A spurious answer set no bit, so auto done must not clear one
						took_q <= raise & ~poll_rd;
					end else if (ack_first) begin
						took_q <= 1'b0;
					end
					if (poll_rd)
						poll_q <= 1'b0;
					// Rotation; an explicit command wins over an automatic done
					if (done_ok & io_wdata[`CVI_O2_ROT_BIT])
						low_q <= done_idx;
					else if (is_op2 & (io_wdata[7:5] == 3'b110))
						low_q <= io_wdata[2:0];
					else if (auto_done & rot_auto_q)
						low_q <= chan_q;
					if (is_op2 & ~io_wdata[`CVI_O2_DONE_BIT] & ~io_wdata[`CVI_O2_SPEC_BIT])
						rot_auto_q <= io_wdata[`CVI_O2_ROT_BIT];
					if (is_op3) begin
						if (io_wdata[`CVI_O3_ESMM_BIT])
							smm_q <= io_wdata[`CVI_O3_SMM_BIT];
						if (io_wdata[`CVI_O3_RR_BIT])
							ris_q <= io_wdata[`CVI_O3_RIS_BIT];
						poll_q <= io_wdata[`CVI_O3_POLL_BIT];
						step_q <= `CVI_STEP_IDLE;
					end
					if (is_op2)
						step_q <= `CVI_STEP_IDLE;
					if (is_init) begin
						level_q <= io_wdata[`CVI_I1_LEVEL_BIT];
						single_q <= io_wdata[`CVI_I1_SINGLE_BIT];
						need4_q <= io_wdata[`CVI_I1_NEED4_BIT];
						auto_q <= 1'b0;
						mask_q <= 8'h00;
						low_q <= `CVI_RST_LOWEST;
						ident_q <= `CVI_RST_IDENT;
						smm_q <= 1'b0;
						ris_q <= 1'b0;
						poll_q <= 1'b0;
						rot_auto_q <= 1'b0;
						step_q <= `CVI_STEP_TWO;
					end else if (wr_odd) begin
						case (step_q)
							`CVI_STEP_IDLE: begin
								mask_q <= io_wdata;
							end
							`CVI_STEP_TWO: begin
								vbase_q <= io_wdata[7:3];
								step_q <= !single_q ? `CVI_STEP_THREE :
									need4_q ? `CVI_STEP_FOUR : `CVI_STEP_IDLE;
							end
							`CVI_STEP_THREE: begin
								ident_q <= io_wdata;
								step_q <= need4_q ? `CVI_STEP_FOUR : `CVI_STEP_IDLE;
							end
							`CVI_STEP_FOUR: begin
								auto_q <= io_wdata[`CVI_I4_AUTO_BIT];
								step_q <= `CVI_STEP_IDLE;
							end
							default: begin
								step_q <= `CVI_STEP_IDLE;
							end
						endcase
					end
				end
			end
		end
	endgenerate

	// Acknowledge sequencing and vector drive
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_phase_q <= 1'b0;
			resp_slave_q <= 1'b0;
			cpu_irq_out <= 1'b0;
			peripheral_data_bus <= 8'h00;
			peripheral_data_oe <= 1'b0;
			io_rdata <= 8'h00;
		end else begin
			if (ack_cycle)
				ack_phase_q <= ~ack_phase_q;
			if (ack_first)
				resp_slave_q <= slv_hit;
			// Request drops on first acknowledge, or when the source withdraws or is masked
			cpu_irq_out <= ctl_int[0] & ~ack_first;
			peripheral_data_oe <= ack_second;
			if (ack_second)
				peripheral_data_bus <= resp_slave_q ? vec_w[1] : vec_w[0];
			if (io_rd)
				io_rdata <= hit[0] ? rd_w[0] : hit[1] ? rd_w[1] : 8'h00;
			else
				io_rdata <= 8'h00;
		end
	end

endmodule // cvi_irq_pair

// File: verilog/cvi_regs.vh
// Constants for the cascaded vectored interrupt controller pair
`ifndef CVI_REGS_VH
`define CVI_REGS_VH

// I/O port addresses, bit 0 selects the even or odd port
`define CVI_MST_BASE 8'h20
`define CVI_SLV_BASE 8'hA0

// Even-port write decoding
`define CVI_W_INIT_BIT 4
`define CVI_W_OP3_BIT 3

// First init word fields
`define CVI_I1_LEVEL_BIT 3
`define CVI_I1_SINGLE_BIT 1
`define CVI_I1_NEED4_BIT 0

// Fourth init word field
`define CVI_I4_AUTO_BIT 1

// Op word two fields
`define CVI_O2_ROT_BIT 7
`define CVI_O2_SPEC_BIT 6
`define CVI_O2_DONE_BIT 5

// Op word three fields
`define CVI_O3_ESMM_BIT 6
`define CVI_O3_SMM_BIT 5
`define CVI_O3_POLL_BIT 2
`define CVI_O3_RR_BIT 1
`define CVI_O3_RIS_BIT 0

// Reset values
`define CVI_RST_MASK 8'h00
`define CVI_RST_LOWEST 3'h7
`define CVI_RST_IDENT 8'h07
`define CVI_RST_VBASE 5'h00
`define CVI_SPUR_CHAN 3'h7

// Init word sequence steps
`define CVI_STEP_IDLE 2'h0
`define CVI_STEP_TWO 2'h1
`define CVI_STEP_THREE 2'h2
`define CVI_STEP_FOUR 2'h3

`endif
